// *** verilog/rcec_classifier.sv ***
// remote command error classifier: event coding, status bits and queue control
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`include "rcec_defines.svh"

// Overview of operation
// - parser syntax errors use codes -199..-100 and set event status bit 5
// - execution errors use codes -299..-200 and set event status bit 4
// - message exchange errors use codes -499..-400 and set bit 2
// - trigger during message reception logs -105 instead of triggering
// - too many parameters logs -108, too few logs -109
// - suffix over twelve characters logs -134, character data over twelve -144
// - suffix after numeric that forbids suffixes logs -138
// - initiate while measuring is ignored and logs -213
// - query before expected software trigger logs deadlock -214
// - received but discarded trigger logs -211
// - out of range value is rejected and logs -222
// - command impossible in present state logs -221
// - data query before measurement finishes logs -230
// - command needing absent option logs -241
// - new command with unread response logs -410
// - read with no query pending queues -100 then -420, sends nothing
// - query after indefinite-form response query in one message logs -440
// - remote operation under local control denied, logs 101
// - operation forbidden with output on denied, logs 102
// - operation during active protection denied, logs 103
// - error query returns next queue entry
// - clear status empties event status and error queue
module rcec_classifier
  import rcec_pkg::*;
#(
  parameter int QUEUE_DEPTH = `RCEC_QUEUE_DEPTH
)
(
  input wire logic clk_i, // 10 mhz clock
  input wire logic reset_i, // synchronous reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire rcec_evt_t evt_i, // one-cycle event pulses
  input wire logic [7:0] suffix_len_i, // length of parsed suffix
  input wire logic suffix_done_i, // suffix length valid
  input wire logic [7:0] chr_len_i, // length of character data
  input wire logic chr_done_i, // char length valid
  input wire logic msg_rx_i, // message reception in progress
  input wire logic meas_busy_i, // measurement running
  input wire logic resp_ready_i, // response placed in output queue
  input wire logic resp_indef_i, // that response has indefinite form
  input wire logic resp_taken_i, // controller read the response
  input wire logic msg_end_i, // end of program message
  output logic trig_accept_o, // trigger may act
  output logic init_accept_o, // initiate may act
  output logic op_accept_o, // checked operation may act
  output logic value_accept_o, // parameter value accepted
  output logic resp_send_o, // output queue may send
  output logic [7:0] esr_o // event status bits
);
  logic [31:0] ctrl;
  logic [16:0] sw_evt;
  logic pop;
  rcec_evt_t ev;
  rcec_entry_t head;
  rcec_entry_t push_a;
  rcec_entry_t push_b;
  logic push_a_v;
  logic push_b_v;
  logic fifo_push;
  rcec_entry_t fifo_data;
  logic fifo_empty;
  logic [7:0] fifo_count;
  logic [7:0] esr_reg;
  logic pend_b_reg;
  rcec_entry_t pend_b_data_reg;
  rcec_rq_state_t rq_reg;
  logic cls;
  logic suf_long;
  logic chr_long;

  // code to message index; used for both queue pushes
  function automatic logic [4:0] text_of(input rcec_code_t c);
    case (c)
      `RCEC_ERR_CMD: text_of = 5'h01;
      `RCEC_ERR_GET: text_of = 5'h02;
      `RCEC_ERR_PAR_MORE: text_of = 5'h03;
      `RCEC_ERR_PAR_LESS: text_of = 5'h04;
      `RCEC_ERR_SUF_LONG: text_of = 5'h05;
      `RCEC_ERR_SUF_NOT: text_of = 5'h06;
      `RCEC_ERR_CHR_LONG: text_of = 5'h07;
      `RCEC_ERR_TRG_IGN: text_of = 5'h08;
      `RCEC_ERR_INIT_IGN: text_of = 5'h09;
      `RCEC_ERR_TRG_DLK: text_of = 5'h0A;
      `RCEC_ERR_CONFLICT: text_of = 5'h0B;
      `RCEC_ERR_RANGE: text_of = 5'h0C;
      `RCEC_ERR_STALE: text_of = 5'h0D;
      `RCEC_ERR_HW_MISS: text_of = 5'h0E;
      `RCEC_ERR_Q_INTR: text_of = 5'h0F;
      `RCEC_ERR_Q_UNTERM: text_of = 5'h10;
      `RCEC_ERR_Q_INDEF: text_of = 5'h11;
      `RCEC_ERR_LOCAL: text_of = 5'h12;
      `RCEC_ERR_OUTON: text_of = 5'h13;
      `RCEC_ERR_PROT: text_of = 5'h14;
      default: text_of = 5'h00;
    endcase
  endfunction : text_of

  // class decode, used for the event status bits
  function automatic logic in_range(input rcec_code_t c, input rcec_code_t lo, input rcec_code_t hi);
    in_range = (c >= lo) && (c <= hi);
  endfunction : in_range

  rcec_apb_slave u_apb (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .status_i({26'h0000000, meas_busy_i, msg_rx_i, fifo_empty, rq_reg}),
    .esr_i(esr_reg),
    .head_i(head),
    .count_i(fifo_count),
    .ctrl_o(ctrl),
    .sw_evt_o(sw_evt),
    .pop_o(pop)
  );

  // software may inject the same events as the parser pins
  assign ev = evt_i | rcec_evt_t'(sw_evt);
  assign cls = ctrl[`RCEC_CTRL_CLS];

  assign suf_long = suffix_done_i && (suffix_len_i > `RCEC_MAX_ELEM_LEN);
  assign chr_long = chr_done_i && (chr_len_i > `RCEC_MAX_ELEM_LEN);

  // accept strobes: denial wins over action
  // trigger blocked
  assign trig_accept_o = !msg_rx_i;
  assign init_accept_o = !meas_busy_i;
  assign op_accept_o = !(ctrl[`RCEC_CTRL_LOCAL] || ctrl[`RCEC_CTRL_OUTON] || ctrl[`RCEC_CTRL_PROT]);
  assign value_accept_o = !ev.value_bad;
  assign resp_send_o = (rq_reg != RQ_IDLE);

  // priority pick of the single error logged this cycle (primary slot)
  always_comb
  begin
    push_a_v = 1'b1;
    push_a.code = `RCEC_ERR_NONE;
    push_b_v = 1'b0;
    push_b.code = `RCEC_ERR_Q_UNTERM;
    push_b.text_id = text_of(`RCEC_ERR_Q_UNTERM);
    if (ev.read_req && rq_reg == RQ_IDLE)
    begin
      push_a.code = `RCEC_ERR_CMD;
      push_b_v = 1'b1;
    end
    else if (ev.cmd_new && rq_reg != RQ_IDLE)
      push_a.code = `RCEC_ERR_Q_INTR;
    else if (ev.indef_then_query && rq_reg == RQ_INDEF)
      push_a.code = `RCEC_ERR_Q_INDEF;
    else if (ev.get_in_msg && msg_rx_i)
      push_a.code = `RCEC_ERR_GET;
    else if (ev.par_more)
      push_a.code = `RCEC_ERR_PAR_MORE;
    else if (ev.par_less)
      push_a.code = `RCEC_ERR_PAR_LESS;
    else if (suf_long)
      push_a.code = `RCEC_ERR_SUF_LONG;
    else if (chr_long)
      push_a.code = `RCEC_ERR_CHR_LONG;
    else if (ev.suffix_on_plain)
      push_a.code = `RCEC_ERR_SUF_NOT;
    else if (ev.op_local_chk && ctrl[`RCEC_CTRL_LOCAL])
      push_a.code = `RCEC_ERR_LOCAL;
    else if (ev.op_outon_chk && ctrl[`RCEC_CTRL_OUTON])
      push_a.code = `RCEC_ERR_OUTON;
    else if (ev.op_prot_chk && ctrl[`RCEC_CTRL_PROT])
      push_a.code = `RCEC_ERR_PROT;
    else if (ev.init_busy && meas_busy_i)
      push_a.code = `RCEC_ERR_INIT_IGN;
    else if (ev.query_before_trig)
      push_a.code = `RCEC_ERR_TRG_DLK;
    else if (ev.trig_dropped)
      push_a.code = `RCEC_ERR_TRG_IGN;
    else if (ev.value_bad)
      push_a.code = `RCEC_ERR_RANGE;
    else if (ev.state_conflict)
      push_a.code = `RCEC_ERR_CONFLICT;
    else if (ev.query_early && meas_busy_i)
      push_a.code = `RCEC_ERR_STALE;
    else if (ev.opt_needed && !ctrl[`RCEC_CTRL_OPTFIT])
      push_a.code = `RCEC_ERR_HW_MISS;
    else
      push_a_v = 1'b0;
    push_a.text_id = text_of(push_a.code);
  end

  // second entry waits one cycle so the queue keeps occurrence order
  always_ff @(posedge clk_i)
  begin
    if (reset_i || cls)
    begin
      pend_b_reg <= 1'b0;
      pend_b_data_reg <= '0;
    end
    else
    begin
      pend_b_reg <= push_a_v && push_b_v;
      pend_b_data_reg <= push_b;
    end
  end

  assign fifo_push = pend_b_reg || push_a_v;
  assign fifo_data = pend_b_reg ? pend_b_data_reg : push_a;

  rcec_err_fifo #(.DEPTH(QUEUE_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(cls),
    .push_i(fifo_push && !cls),
    .push_data_i(fifo_data),
    .pop_i(pop),
    .head_o(head),
    .empty_o(fifo_empty),
    .count_o(fifo_count)
  );

  // class bits; a new error beats the clear
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      esr_reg <= 8'h00;
    else
    begin
      if (cls)
        esr_reg <= 8'h00;
      if (fifo_push)
      begin
        if (in_range(fifo_data.code, `RCEC_CMD_LO, `RCEC_CMD_HI))
          esr_reg[`RCEC_ESR_CME] <= 1'b1;
        if (in_range(fifo_data.code, `RCEC_EXE_LO, `RCEC_EXE_HI))
          esr_reg[`RCEC_ESR_EXE] <= 1'b1;
        if (in_range(fifo_data.code, `RCEC_QRY_LO, `RCEC_QRY_HI))
          esr_reg[`RCEC_ESR_QYE] <= 1'b1;
      end
    end
  end

  assign esr_o = esr_reg;

  // response tracking for the query-error checks
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      rq_reg <= RQ_IDLE;
    else
    begin
      case (rq_reg)
        RQ_IDLE:
        begin
          if (resp_ready_i)
            rq_reg <= resp_indef_i ? RQ_INDEF : RQ_PEND;
        end
        RQ_PEND, RQ_INDEF:
        begin
          if (resp_taken_i || ev.cmd_new)
            rq_reg <= RQ_IDLE;
          else if (msg_end_i && rq_reg == RQ_INDEF)
            rq_reg <= RQ_PEND;
        end
        default: rq_reg <= RQ_IDLE;
      endcase
    end
  end
endmodule : rcec_classifier

// *** pkg/rcec_defines.svh ***
// offsets, field positions, codes and sizes for the remote command error classifier
`ifndef RCEC_DEFINES_SVH
`define RCEC_DEFINES_SVH
`define RCEC_OFF_CTRL 8'h00
`define RCEC_OFF_STATUS 8'h04
`define RCEC_OFF_EVENT 8'h08
`define RCEC_OFF_ESR 8'h0C
`define RCEC_OFF_ERRPOP 8'h10
`define RCEC_OFF_ERRCODE 8'h14
`define RCEC_OFF_ERRTEXT 8'h18
`define RCEC_OFF_COUNT 8'h1C
`define RCEC_ESR_QYE 2
`define RCEC_ESR_EXE 4
`define RCEC_ESR_CME 5
`define RCEC_CTRL_CLS 0
`define RCEC_CTRL_LOCAL 1
`define RCEC_CTRL_OUTON 2
`define RCEC_CTRL_PROT 3
`define RCEC_CTRL_OPTFIT 4
`define RCEC_CTRL_RESET 32'h0000_0000
`define RCEC_MAX_ELEM_LEN 8'h0C
`define RCEC_QUEUE_DEPTH 16
`define RCEC_ERR_NONE 16'sh0000
`define RCEC_ERR_CMD 16'shFF9C
`define RCEC_ERR_GET 16'shFF97
`define RCEC_ERR_PAR_MORE 16'shFF94
`define RCEC_ERR_PAR_LESS 16'shFF93
`define RCEC_ERR_SUF_LONG 16'shFF7A
`define RCEC_ERR_SUF_NOT 16'shFF76
`define RCEC_ERR_CHR_LONG 16'shFF70
`define RCEC_ERR_TRG_IGN 16'shFF2D
`define RCEC_ERR_INIT_IGN 16'shFF2B
`define RCEC_ERR_TRG_DLK 16'shFF2A
`define RCEC_ERR_CONFLICT 16'shFF23
`define RCEC_ERR_RANGE 16'shFF22
`define RCEC_ERR_STALE 16'shFF1A
`define RCEC_ERR_HW_MISS 16'shFF0F
`define RCEC_ERR_Q_INTR 16'shFE66
`define RCEC_ERR_Q_UNTERM 16'shFE5C
`define RCEC_ERR_Q_INDEF 16'shFE48
`define RCEC_ERR_LOCAL 16'sh0065
`define RCEC_ERR_OUTON 16'sh0066
`define RCEC_ERR_PROT 16'sh0067
`define RCEC_CMD_LO 16'shFF39
`define RCEC_CMD_HI 16'shFF9C
`define RCEC_EXE_LO 16'shFED5
`define RCEC_EXE_HI 16'shFF38
`define RCEC_QRY_LO 16'shFE0D
`define RCEC_QRY_HI 16'shFE70
`endif

// *** pkg/rcec_pkg.sv ***
// types shared by the remote command error classifier files
package rcec_pkg;
  typedef logic signed [15:0] rcec_code_t;

  // event word from parser, execution and output-queue control, one bit per event; several may be set in one cycle
  typedef struct packed {
    logic get_in_msg;
    logic par_more;
    logic par_less;
    logic suffix_on_plain;
    logic init_busy;
    logic query_before_trig;
    logic trig_dropped;
    logic value_bad;
    logic state_conflict;
    logic query_early;
    logic opt_needed;
    logic cmd_new;
    logic read_req;
    logic indef_then_query;
    logic op_local_chk;
    logic op_outon_chk;
    logic op_prot_chk;
  } rcec_evt_t;

  // one logged entry: signed code plus message index
  typedef struct packed {
    rcec_code_t code;
    logic [4:0] text_id;
  } rcec_entry_t;

  typedef enum logic [2:0] {
    RQ_IDLE = 3'b001,
    RQ_PEND = 3'b010,
    RQ_INDEF = 3'b100
  } rcec_rq_state_t;
endpackage : rcec_pkg

// *** verilog/rcec_err_fifo.sv ***
// ordered error queue holding signed codes and message ids
`timescale 1ns/1ps
module rcec_err_fifo
  import rcec_pkg::*;
#(
  parameter int DEPTH = `RCEC_QUEUE_DEPTH
)
(
  input wire logic clk_i, // system clock
  input wire logic reset_i, // synchronous reset
  input wire logic clear_i, // empty the queue
  input wire logic push_i, // log one entry
  input wire rcec_entry_t push_data_i, // entry to log
  input wire logic pop_i, // drop the head entry
  output rcec_entry_t head_o, // oldest entry
  output logic empty_o, // nothing logged
  output logic [7:0] count_o // entries held
);
  localparam int AW = $clog2(DEPTH);
  rcec_entry_t mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [7:0] cnt_reg;
  logic do_push;
  logic do_pop;

  // full queue drops the newest entry, keeping the oldest ones in order
  assign do_pop = pop_i && (cnt_reg != 8'h00);
  assign do_push = push_i && ((cnt_reg != 8'(DEPTH)) || do_pop);

  // storage writes
  always_ff @(posedge clk_i)
  begin
    if (do_push)
    begin
      mem[wr_reg] <= push_data_i;
    end
  end

  // pointers and count
  always_ff @(posedge clk_i)
  begin
    if (reset_i || clear_i)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= 8'h00;
    end
    else
    begin
      if (do_push)
        wr_reg <= AW'(wr_reg + 1'b1);
      if (do_pop)
        rd_reg <= AW'(rd_reg + 1'b1);
      cnt_reg <= 8'(cnt_reg + {7'h00, do_push} - {7'h00, do_pop});
    end
  end

  assign head_o = (cnt_reg == 8'h00) ? '0 : mem[rd_reg];
  assign empty_o = (cnt_reg == 8'h00);
  assign count_o = cnt_reg;
endmodule : rcec_err_fifo

// *** verilog/rcec_apb_slave.sv ***
// apb register file for control, status and error queue readout
`timescale 1ns/1ps
module rcec_apb_slave
  import rcec_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic reset_i, // synchronous reset
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [31:0] status_i, // block status word
  input wire logic [7:0] esr_i, // event status bits
  input wire rcec_entry_t head_i, // queue head
  input wire logic [7:0] count_i, // queue depth used
  output logic [31:0] ctrl_o, // control register
  output logic [16:0] sw_evt_o, // software event pulses
  output logic pop_o // error read pulse
);
  logic access;
  logic [31:0] ctrl_reg;
  logic [31:0] rdata_next;
  logic known;

  // single-cycle access phase, zero wait states
  assign access = psel && penable;
  assign pready = 1'b1;

  // address decode
  always_comb
  begin
    known = 1'b1;
    rdata_next = 32'h0000_0000;
    case (paddr)
      `RCEC_OFF_CTRL: rdata_next = ctrl_reg;
      `RCEC_OFF_STATUS: rdata_next = status_i;
      `RCEC_OFF_EVENT: rdata_next = 32'h0000_0000;
      `RCEC_OFF_ESR: rdata_next = {24'h000000, esr_i};
      `RCEC_OFF_ERRPOP: rdata_next = {{16{head_i.code[15]}}, head_i.code};
      `RCEC_OFF_ERRCODE: rdata_next = {{16{head_i.code[15]}}, head_i.code};
      `RCEC_OFF_ERRTEXT: rdata_next = {27'h0000000, head_i.text_id};
      `RCEC_OFF_COUNT: rdata_next = {24'h000000, count_i};
      default: known = 1'b0;
    endcase
  end

  assign prdata = access ? rdata_next : 32'h0000_0000;
  assign pslverr = access && !known;

  // control register; clear-status bit self-clears
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      ctrl_reg <= `RCEC_CTRL_RESET;
    else if (access && pwrite && paddr == `RCEC_OFF_CTRL)
      ctrl_reg <= pwdata;
    else
      ctrl_reg[`RCEC_CTRL_CLS] <= 1'b0;
  end

  assign ctrl_o = ctrl_reg;
  assign sw_evt_o = (access && pwrite && paddr == `RCEC_OFF_EVENT) ? pwdata[16:0] : 17'h00000;
  // reading the pop word consumes the head entry
  assign pop_o = access && !pwrite && paddr == `RCEC_OFF_ERRPOP;
endmodule : rcec_apb_slave

// *** dv/rcec_props.sv ***
// concurrent checks on the error classifier ports
`timescale 1ns/1ps
module rcec_props
  import rcec_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic reset_i, // sync reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb data
  input wire rcec_evt_t evt_i, // event pulses
  input wire logic suffix_done_i, // suffix strobe
  input wire logic chr_done_i, // char strobe
  input wire logic msg_rx_i, // message in progress
  input wire logic meas_busy_i, // measuring
  input wire logic trig_accept_o, // trigger may act
  input wire logic init_accept_o, // initiate may act
  input wire logic value_accept_o, // value taken
  input wire logic resp_send_o, // response pending
  input wire logic [7:0] esr_o // event status
);
  // a lone event, so error priority plays no part
  logic solo;
  logic cls_wr;
  assign solo = $onehot(evt_i) && !suffix_done_i && !chr_done_i;
  assign cls_wr = psel && penable && pwrite && paddr == 8'h00 && pwdata[0];
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // class bits land one edge after the event
  AST_CMD_BIT:
    assert property (solo && evt_i.par_more |=> esr_o[5]) else $error("command bit missing");
  AST_EXE_BIT:
    assert property (solo && evt_i.value_bad |=> esr_o[4]) else $error("execution bit missing");
  AST_QRY_BIT:
    assert property (solo && evt_i.cmd_new && resp_send_o |=> esr_o[2]) else $error("query bit missing");
  // second entry follows the first by one edge
  AST_UNTERM:
    assert property (solo && evt_i.read_req && !resp_send_o |=> esr_o[5] ##1 esr_o[2])
      else $error("unterminated read not flagged");
  // bits hold until a clear
  AST_STICKY:
    assert property (!cls_wr && !$past(cls_wr) |=> (esr_o & $past(esr_o)) == $past(esr_o))
      else $error("status bit lost");
  // clear bit is registered, so the status clears one edge after the write
  AST_CLEAR:
    assert property (cls_wr && evt_i == '0 && !suffix_done_i && !chr_done_i && !$past(evt_i.read_req)
      ##1 evt_i == '0 && !suffix_done_i && !chr_done_i |=> esr_o == 8'h00) else $error("clear left status bits");
  AST_TRIG:
    assert property (trig_accept_o == !msg_rx_i) else $error("trigger accepted in message");
  AST_INIT:
    assert property (meas_busy_i |-> !init_accept_o) else $error("initiate accepted while busy");
  AST_VALUE:
    assert property (evt_i.value_bad |-> !value_accept_o) else $error("bad value accepted");
endmodule : rcec_props

// *** dv/rcec_ctl_model.sv ***
// remote controller model driving the message-side inputs
`timescale 1ns/1ps
module rcec_ctl_model
  import rcec_pkg::*;
(
  input wire logic clk_i, // system clock
  output rcec_evt_t evt_o, // event pulses
  output logic [7:0] suffix_len_o, // suffix length
  output logic suffix_done_o, // suffix valid
  output logic [7:0] chr_len_o, // char length
  output logic chr_done_o, // char valid
  output logic msg_rx_o, // message in reception
  output logic meas_busy_o, // measuring
  output logic resp_ready_o, // response queued
  output logic resp_indef_o, // indefinite form
  output logic resp_taken_o, // response read back
  output logic msg_end_o // end of program message
);
  // quiet lines at time zero
  initial
  begin
    evt_o = '0;
    suffix_len_o = 8'h00;
    suffix_done_o = 1'b0;
    chr_len_o = 8'h00;
    chr_done_o = 1'b0;
    msg_rx_o = 1'b0;
    meas_busy_o = 1'b0;
    resp_ready_o = 1'b0;
    resp_indef_o = 1'b0;
    resp_taken_o = 1'b0;
    msg_end_o = 1'b0;
  end
  // one-cycle pulse of event bit n
  task automatic send(input int n);
    @(posedge clk_i);
    evt_o <= rcec_evt_t'(17'h0_0001 << n);
    @(posedge clk_i);
    evt_o <= '0;
  endtask : send
  // length strobe; lengths scrambled once released
  task automatic elem(input logic sfx, input logic [7:0] n);
    @(posedge clk_i);
    suffix_len_o <= n;
    chr_len_o <= n;
    suffix_done_o <= sfx;
    chr_done_o <= !sfx;
    @(posedge clk_i);
    suffix_done_o <= 1'b0;
    chr_done_o <= 1'b0;
    suffix_len_o <= ~n;
    chr_len_o <= ~n;
  endtask : elem
  task automatic resp(input logic indef);
    @(posedge clk_i);
    resp_ready_o <= 1'b1;
    resp_indef_o <= indef;
    @(posedge clk_i);
    resp_ready_o <= 1'b0;
    resp_indef_o <= !indef;
  endtask : resp
  task automatic take();
    @(posedge clk_i);
    resp_taken_o <= 1'b1;
    @(posedge clk_i);
    resp_taken_o <= 1'b0;
  endtask : take
  // closes the message, so an indefinite response no longer blocks queries
  task automatic fin();
    @(posedge clk_i);
    msg_end_o <= 1'b1;
    @(posedge clk_i);
    msg_end_o <= 1'b0;
  endtask : fin
  // message and measurement levels
  task automatic level(input logic rx, input logic busy);
    @(posedge clk_i);
    msg_rx_o <= rx;
    meas_busy_o <= busy;
  endtask : level
endmodule : rcec_ctl_model

// *** dv/testbench.sv ***
// self-checking bench for the remote command error classifier
`timescale 1ns/1ps
module testbench
  import rcec_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_i;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr, slverr_q;
  rcec_evt_t evt_i;
  logic [7:0] suffix_len_i, chr_len_i;
  logic suffix_done_i, chr_done_i, msg_rx_i, meas_busy_i;
  logic resp_ready_i, resp_indef_i, resp_taken_i;
  logic msg_end_i;
  logic trig_accept_o, init_accept_o, op_accept_o, value_accept_o, resp_send_o;
  logic [7:0] esr_o;
  int mismatches = 0;
  int compares = 0;
  int exe_bits [7] = '{12, 11, 10, 9, 8, 7, 6};
  logic [15:0] cmd_codes [6] = '{16'hFF97, 16'hFF94, 16'hFF93, 16'hFF76, 16'hFF7A, 16'hFF70};
  logic [15:0] exe_codes [10] = '{16'hFF2B, 16'hFF2A, 16'hFF2D, 16'hFF22, 16'hFF23, 16'hFF1A,
                                   16'hFF0F, 16'h0065, 16'h0066, 16'h0067};
  logic [15:0] qry_codes [4] = '{16'hFF9C, 16'hFE5C, 16'hFE66, 16'hFE48};

  always #50 clk_i = ~clk_i;

  rcec_classifier dut (.*);
  rcec_ctl_model ctl (
    .clk_i(clk_i),
    .evt_o(evt_i),
    .suffix_len_o(suffix_len_i),
    .suffix_done_o(suffix_done_i),
    .chr_len_o(chr_len_i),
    .chr_done_o(chr_done_i),
    .msg_rx_o(msg_rx_i),
    .meas_busy_o(meas_busy_i),
    .resp_ready_o(resp_ready_i),
    .resp_indef_o(resp_indef_i),
    .resp_taken_o(resp_taken_i),
    .msg_end_o(msg_end_i)
  );

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // apb transfer held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do
      @(posedge clk_i);
    while (pready !== 1'b1);
    // taken at the completing edge, before a pop or write lands
    r = prdata;
    slverr_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    chk(r, e);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr

  // codes read back sign-extended
  task automatic pop(input logic [15:0] c);
    rd(8'h10, {{16{c[15]}}, c});
  endtask : pop

  // watchdog: the run needs well under a thousand cycles
  initial
  begin
    #300000;
    mismatches++;
    conclude();
  end

  initial
  begin
    reset_i <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    // reset values and an unmapped place
    rd(8'h00, 32'h0000_0000);
    rd(8'h0C, 32'h0000_0000);
    rd(8'h1C, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    rd(8'h08, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    chk(32'(slverr_q), 32'h0000_0001);
    // parser errors, lengths at and past the limit
    ctl.level(1'b1, 1'b1);
    @(negedge clk_i);
    chk(32'({trig_accept_o, init_accept_o, op_accept_o}), 32'h0000_0001);
    ctl.send(16);
    ctl.send(15);
    ctl.send(14);
    ctl.send(13);
    ctl.elem(1'b1, 8'h0C);
    ctl.elem(1'b1, 8'h0D);
    ctl.elem(1'b0, 8'h0C);
    ctl.elem(1'b0, 8'h0D);
    rd(8'h1C, 32'h0000_0006);
    rd(8'h0C, 32'h0000_0020);
    rd(8'h18, 32'h0000_0002);
    foreach (cmd_codes[i]) pop(cmd_codes[i]);
    rd(8'h10, 32'h0000_0000);
    wr(8'h00, 32'h0000_0001);
    rd(8'h0C, 32'h0000_0000);
    // execution errors, then denials per control state
    foreach (exe_bits[i]) ctl.send(exe_bits[i]);
    rd(8'h0C, 32'h0000_0010);
    wr(8'h00, 32'h0000_0010);
    ctl.send(6);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h00, 32'h0000_0002 << i);
      @(negedge clk_i);
      chk(32'(op_accept_o), 32'h0000_0000);
      ctl.send(2 - i);
    end
    rd(8'h1C, 32'h0000_000A);
    foreach (exe_codes[i]) pop(exe_codes[i]);
    // message exchange faults
    wr(8'h00, 32'h0000_0001);
    ctl.level(1'b0, 1'b0);
    @(negedge clk_i);
    chk(32'({trig_accept_o, init_accept_o, op_accept_o}), 32'h0000_0007);
    ctl.send(4);
    @(negedge clk_i);
    chk(32'(resp_send_o), 32'h0000_0000);
    ctl.resp(1'b0);
    @(negedge clk_i);
    chk(32'(resp_send_o), 32'h0000_0001);
    ctl.send(5);
    ctl.take();
    ctl.resp(1'b1);
    ctl.send(3);
    ctl.take();
    rd(8'h0C, 32'h0000_0024);
    foreach (qry_codes[i]) pop(qry_codes[i]);
    // a query after the message end is legal
    ctl.resp(1'b1);
    ctl.fin();
    ctl.send(3);
    @(negedge clk_i);
    chk(32'(resp_send_o), 32'h0000_0001);
    ctl.take();
    rd(8'h1C, 32'h0000_0000);
    // software injection until the queue refuses
    wr(8'h00, 32'h0000_0001);
    repeat (17) wr(8'h08, 32'h0000_8000);
    rd(8'h1C, 32'h0000_0010);
    pop(16'hFF94);
    wr(8'h00, 32'h0000_0001);
    rd(8'h1C, 32'h0000_0000);
    rd(8'h0C, 32'h0000_0000);
    conclude();
  end
endmodule : testbench

bind rcec_classifier rcec_props props_chk (.*);
